// *** design/ast_translator.sv ***
// Address space translator: processor to system address and back
// How it works
// (R1) System address top bits 39..36 select one of sixteen equal stations.
// (R2) Outgoing system address bits 31..28 are forced to zero.
// (R3) Selector moves from processor bits 31..28 to system bits 35..32.
// (R4) Processor bits 35..32 become station bits; offset 27..0 passes through.
// (R5) Routing information fills bits 63..40 above the system address.
// (R6) Incoming path reverses the mapping; bits 63..36 left untouched.
// (R7) Selector in bits 35..32 decides how offset bits 27..0 are used.
// (R8) Selector 0x0 is local DRAM alias, 0xf normal memory by station.
// (R9) Selector 0x1 reaches card-local resources.
// (R10) Selector 0x4 special functions, 0x8 remote interrupt or monitoring writes.
// (R11) Selectors 0x2, 0x6, 0x7: netcache writeback, kill, prefetch by address.
// (R12) Selector 0x3 atomic netcache DRAM by index, 0x9 indexed netcache ops.
// (R13) Selector 0x5 starts memory update, 0xc starts memory broadcast.
// (R14) Selectors 0xa, 0xb, 0xd: atomic directory, atomic DRAM, directory.
// (R15) Selector 0xe goes to the I/O card.
// (R16) Selectors 0x2,0x3,0x5,0x6,0x7,0x9 route by the filter mask.
// (R17) Selector 0x8 routes by filter mask or by station field.
// (R18) Bits 27..26 decode as a selector-specific extension.
// (R19) DRAM selectors use a 28-bit per-station offset.
// (R20) Processor places selector at 31..28 and station at 35..32.
// (R21) Station decodes to 8-bit destination mask at 47..40; source id at 63..52.
// (R22) Filter mask never replaces source bits 63..52.
`timescale 1ns/1ps
`default_nettype none
module ast_translator (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        out_valid,
  input  wire logic [35:0] out_cpu_addr,
  input  wire logic [7:0]  filter_mask,
  input  wire logic        fm_force,
  input  wire logic        fm_select,
  input  wire logic [11:0] source_id,
  output var  logic        out_word_valid,
  output var  logic [63:0] out_word,
  output var  logic [3:0]  out_target,
  output var  logic [1:0]  out_ext,
  output var  logic        out_is_dram,
  output var  logic        out_atomic,
  output var  logic        out_fm_used,
  input  wire logic        in_valid,
  input  wire logic [63:0] in_word,
  output var  logic        in_addr_valid,
  output var  logic [63:0] in_cpu_word
);
  typedef struct packed {
    logic        ov;
    logic [63:0] ow;
    logic [3:0]  tgt;
    logic [1:0]  ext;
    logic        dram;
    logic        atom;
    logic        fmu;
    logic        iv;
    logic [63:0] iw;
  } ast_state_t;

  ast_state_t st_reg;
  ast_state_t st_next;
  ast_dec_if  dif ();

  logic [3:0]  sel_in;
  logic [3:0]  stn_in;
  logic [39:0] sys_addr;
  logic [7:0]  stn_mask;
  logic        use_fm;

  // Processor delivers selector and station in its own bit slots
  assign sel_in  = out_cpu_addr[ast_pkg::SEL_CPU_HI:ast_pkg::SEL_CPU_LO]; // (R20)
  assign stn_in  = out_cpu_addr[ast_pkg::STN_CPU_HI:ast_pkg::STN_CPU_LO]; // (R20)
  assign dif.sel = ast_pkg::ast_sel_t'(sel_in); // (R7)
  assign dif.ext = out_cpu_addr[ast_pkg::EXT_HI:ast_pkg::EXT_LO]; // (R18)

  ast_sel_decode u_dec (
    .d (dif)
  );

  // Sixteen stations share eight mask bits: ring one-hot in the upper four, station in the lower
  always_comb begin
    stn_mask = 8'h00;
    stn_mask[{1'b1, stn_in[3:2]}] = 1'b1; // (R21)
    stn_mask[{1'b0, stn_in[1:0]}] = 1'b1; // (R21)
  end

  always_comb begin
    sys_addr = {stn_in, sel_in, ast_pkg::ZERO_NIB, // (R1) (R3) (R4) (R2)
                out_cpu_addr[ast_pkg::OFS_HI:ast_pkg::OFS_LO]}; // (R4) (R19)
    unique case (dif.fm)
      ast_pkg::FM_ALWAYS: use_fm = 1'b1; // (R16)
      ast_pkg::FM_EITHER: use_fm = fm_select | fm_force; // (R17)
      default:            use_fm = fm_force;
    endcase
  end

  always_comb begin
    st_next      = st_reg;
    st_next.ov   = out_valid;
    st_next.iv   = in_valid;
    if (out_valid) begin
      st_next.ow   = {source_id, 4'h0, (use_fm ? filter_mask : stn_mask), sys_addr}; // (R5) (R22)
      st_next.tgt  = dif.tgt;
      st_next.ext  = dif.ext;
      st_next.dram = dif.is_dram;
      st_next.atom = dif.atomic;
      st_next.fmu  = use_fm;
    end
    if (in_valid) begin
      // Top 28 bits are ignored by the processor, so they ride along as-is
      st_next.iw = {in_word[63:36], in_word[39:36],
                    in_word[35:32], in_word[27:0]}; // (R6)
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_word_valid = st_reg.ov;
  assign out_word       = st_reg.ow;
  assign out_target     = st_reg.tgt;
  assign out_ext        = st_reg.ext;
  assign out_is_dram    = st_reg.dram;
  assign out_atomic     = st_reg.atom;
  assign out_fm_used    = st_reg.fmu;
  assign in_addr_valid  = st_reg.iv;
  assign in_cpu_word    = st_reg.iw;
endmodule // ast_translator
`default_nettype wire

// *** inc/ast_pkg.sv ***
// Constants and types for the address space translator
package ast_pkg;
  localparam int STN_HI        = 39;
  localparam int STN_LO        = 36;
  localparam int SEL_SYS_HI    = 35;
  localparam int SEL_SYS_LO    = 32;
  localparam int SEL_CPU_HI    = 31;
  localparam int SEL_CPU_LO    = 28;
  localparam int STN_CPU_HI    = 35;
  localparam int STN_CPU_LO    = 32;
  localparam int OFS_HI        = 27;
  localparam int OFS_LO        = 0;
  localparam int EXT_HI        = 27;
  localparam int EXT_LO        = 26;
  localparam int ROUTE_HI      = 63;
  localparam int ROUTE_LO      = 40;
  localparam int DMASK_HI      = 47;
  localparam int DMASK_LO      = 40;
  localparam int SRC_HI        = 63;
  localparam int SRC_LO        = 52;
  localparam int NUM_STATIONS  = 16;
  localparam int DRAM_OFS_BITS = 28;
  localparam logic [3:0] ZERO_NIB = 4'h0;

  typedef enum logic [3:0] {
    sel_local_dram_alias       = 4'h0,
    sel_card_local_resources   = 4'h1,
    sel_netcache_writeback     = 4'h2,
    sel_netcache_atomic_dram   = 4'h3,
    sel_special_functions      = 4'h4,
    sel_memory_update          = 4'h5,
    sel_netcache_line_kill     = 4'h6,
    sel_netcache_prefetch      = 4'h7,
    sel_remote_interrupt_write = 4'h8,
    sel_netcache_indexed_ops   = 4'h9,
    sel_atomic_directory       = 4'ha,
    sel_atomic_memory_dram     = 4'hb,
    sel_memory_broadcast       = 4'hc,
    sel_directory_access       = 4'hd,
    sel_io_operations          = 4'he,
    sel_normal_memory          = 4'hf
  } ast_sel_t;

  // Target resource, binary code
  typedef enum logic [3:0] {
    TGT_MEMORY    = 4'h0,
    TGT_CARD      = 4'h1,
    TGT_NETCACHE  = 4'h2,
    TGT_SPECIAL   = 4'h3,
    TGT_INTERRUPT = 4'h4,
    TGT_IO        = 4'h5
  } ast_tgt_t;

  // Filter-mask routing: 0 never, 1 always, 2 either (mask or address)
  typedef enum logic [1:0] {
    FM_NEVER  = 2'h0,
    FM_ALWAYS = 2'h1,
    FM_EITHER = 2'h2
  } ast_fm_t;
endpackage

// *** inc/ast_dec_if.sv ***
// Selector decode carrier between translator and decoder
`timescale 1ns/1ps
`default_nettype none
interface ast_dec_if;
  ast_pkg::ast_sel_t sel;
  logic [1:0]        ext;
  ast_pkg::ast_tgt_t tgt;
  ast_pkg::ast_fm_t  fm;
  logic              is_dram;
  logic              atomic;
  modport req (output sel, output ext, input tgt, input fm, input is_dram, input atomic);
  modport dec (input sel, input ext, output tgt, output fm, output is_dram, output atomic);
endinterface
`default_nettype wire

// *** design/ast_sel_decode.sv ***
// Space-selector decoder: target resource, routing source and access kind
`timescale 1ns/1ps
`default_nettype none
module ast_sel_decode (
  ast_dec_if.dec d
);
  always_comb begin
    d.tgt     = ast_pkg::TGT_MEMORY;
    d.fm      = ast_pkg::FM_NEVER;
    d.is_dram = 1'b0;
    d.atomic  = 1'b0;
    unique case (d.sel)
      ast_pkg::sel_local_dram_alias: begin // (R8) (R19)
        d.is_dram = 1'b1;
      end
      ast_pkg::sel_card_local_resources: begin // (R9)
        d.tgt = ast_pkg::TGT_CARD;
      end
      ast_pkg::sel_netcache_writeback, ast_pkg::sel_netcache_line_kill,
      ast_pkg::sel_netcache_prefetch: begin // (R11) (R16)
        d.tgt = ast_pkg::TGT_NETCACHE;
        d.fm  = ast_pkg::FM_ALWAYS;
      end
      ast_pkg::sel_netcache_atomic_dram: begin // (R12) (R16)
        d.tgt    = ast_pkg::TGT_NETCACHE;
        d.fm     = ast_pkg::FM_ALWAYS;
        d.atomic = 1'b1;
      end
      ast_pkg::sel_netcache_indexed_ops: begin // (R12) (R16) (R18)
        d.tgt    = ast_pkg::TGT_NETCACHE;
        d.fm     = ast_pkg::FM_ALWAYS;
        d.atomic = (d.ext == 2'h3);
      end
      ast_pkg::sel_special_functions: begin // (R10)
        d.tgt = ast_pkg::TGT_SPECIAL;
      end
      ast_pkg::sel_memory_update: begin // (R13) (R16)
        d.fm = ast_pkg::FM_ALWAYS;
      end
      ast_pkg::sel_remote_interrupt_write: begin // (R10) (R17)
        d.tgt = ast_pkg::TGT_INTERRUPT;
        d.fm  = ast_pkg::FM_EITHER;
      end
      ast_pkg::sel_atomic_directory, ast_pkg::sel_atomic_memory_dram: begin // (R14)
        d.atomic = 1'b1;
      end
      ast_pkg::sel_memory_broadcast, ast_pkg::sel_directory_access: begin // (R13) (R14)
      end
      ast_pkg::sel_io_operations: begin // (R15)
        d.tgt = ast_pkg::TGT_IO;
      end
      ast_pkg::sel_normal_memory: begin // (R8) (R19)
        d.is_dram = 1'b1;
      end
    endcase
  end
endmodule // ast_sel_decode
`default_nettype wire

// *** verif/ast_translator_assertions.sv ***
// Port checker for the address space translator
`timescale 1ns/1ps
`default_nettype none
module ast_translator_chk (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        out_valid,
  input wire logic [35:0] out_cpu_addr,
  input wire logic [7:0]  filter_mask,
  input wire logic        fm_force,
  input wire logic [11:0] source_id,
  input wire logic        out_word_valid,
  input wire logic [63:0] out_word,
  input wire logic [1:0]  out_ext,
  input wire logic        out_is_dram,
  input wire logic        out_fm_used,
  input wire logic        in_valid,
  input wire logic [63:0] in_word,
  input wire logic [63:0] in_cpu_word
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_zero_gap: assert property (out_valid |=> out_word_valid && out_word[31:28] == 4'h0)
    else $error("gap bits not zero");
  a_sel_moved: assert property (out_valid |=> out_word[35:32] == $past(out_cpu_addr[31:28]))
    else $error("selector misplaced");
  a_stn_ofs: assert property (out_valid |=> out_word[39:36] == $past(out_cpu_addr[35:32])
    && out_word[27:0] == $past(out_cpu_addr[27:0]))
    else $error("station or offset wrong");
  a_src_kept: assert property (out_valid |=> out_word[63:52] == $past(source_id))
    else $error("source bits wrong");
  a_fm_route: assert property (out_valid && fm_force |=> out_fm_used
    && out_word[47:40] == $past(filter_mask))
    else $error("mask override missing");
  a_fm_sel: assert property (out_valid
    && out_cpu_addr[31:28] inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9}
    |=> out_fm_used && out_word[47:40] == $past(filter_mask))
    else $error("selector mask routing missing");
  a_stn_mask: assert property (out_valid && !fm_force
    && !(out_cpu_addr[31:28] inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9})
    |=> !out_fm_used && out_word[47:40] == ((8'h10 << $past(out_cpu_addr[35:34]))
    | (8'h01 << $past(out_cpu_addr[33:32]))))
    else $error("station mask wrong");
  a_in_reverse: assert property (in_valid |=> in_cpu_word == {$past(in_word[63:36]),
    $past(in_word[39:32]), $past(in_word[27:0])})
    else $error("incoming map wrong");
  a_dram_flag: assert property (out_valid |=> out_is_dram ==
    ($past(out_cpu_addr[31:28]) inside {4'h0, 4'hf}))
    else $error("dram flag wrong");
  a_ext_field: assert property (out_valid |=> out_ext == $past(out_cpu_addr[27:26]))
    else $error("extension wrong");
endmodule // ast_translator_chk
`default_nettype wire

// *** verif/ast_cpu_model.sv ***
// Processor model: builds the physical address it issues
`timescale 1ns/1ps
`default_nettype none
module ast_cpu_model (
  input  wire logic [3:0]  stn,
  input  wire logic [3:0]  sel,
  input  wire logic [27:0] ofs,
  output var  logic [35:0] addr
);
  assign addr = {stn, sel, ofs};
endmodule // ast_cpu_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the address space translator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0, arst_n = 1'b0, out_valid = 1'b0, in_valid = 1'b0;
  logic        fm_force = 1'b0, fm_select = 1'b0;
  logic [3:0]  stn = 4'h0, sel = 4'h0;
  logic [27:0] ofs = 28'h0;
  logic [35:0] cpu_addr;
  logic [7:0]  filter_mask = 8'ha5;
  logic [11:0] source_id = 12'h3c1;
  logic [63:0] in_word = 64'h0, out_word, in_cpu_word;
  logic [3:0]  out_target;
  logic [1:0]  out_ext;
  logic        out_word_valid, out_is_dram, out_atomic, out_fm_used, in_addr_valid;
  int          miscompares = 0, checks = 0, cycles = 0;
  // Expected target per selector row
  logic [3:0]  tgt_row [16] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h0, 4'h2, 4'h2,
                                 4'h4, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'h0};
  always #2 clk_sys = ~clk_sys;
  ast_cpu_model cpu_u (.stn(stn), .sel(sel), .ofs(ofs), .addr(cpu_addr));
  ast_translator dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .out_valid(out_valid),
    .out_cpu_addr(cpu_addr), .filter_mask(filter_mask), .fm_force(fm_force),
    .fm_select(fm_select), .source_id(source_id), .out_word_valid(out_word_valid),
    .out_word(out_word), .out_target(out_target), .out_ext(out_ext),
    .out_is_dram(out_is_dram), .out_atomic(out_atomic), .out_fm_used(out_fm_used),
    .in_valid(in_valid), .in_word(in_word), .in_addr_valid(in_addr_valid),
    .in_cpu_word(in_cpu_word));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Ceiling well above the 60 or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 500) begin
      miscompares++;
      give_verdict();
    end
  end
  function automatic logic fm_on(input logic [3:0] s);
    return fm_force || s inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9} || (s == 4'h8 && fm_select);
  endfunction
  function automatic logic [63:0] exp_w(input logic [3:0] t, s, input logic [27:0] o);
    logic [7:0] m;
    m = fm_on(s) ? filter_mask : (8'h10 << t[3:2]) | (8'h01 << t[1:0]);
    return {source_id, 4'h0, m, t, s, 4'h0, o};
  endfunction
  task automatic send(input logic [3:0] t, s, input logic [27:0] o, input logic fs);
    @(posedge clk_sys);
    stn       <= t;
    sel       <= s;
    ofs       <= o;
    fm_select <= fs;
    out_valid <= 1'b1;
    @(posedge clk_sys);
    out_valid <= 1'b0;
    #1;
  endtask
  initial begin
    logic [1:0] e;
    repeat (11) @(posedge clk_sys);
    #1 chk({out_word_valid, in_addr_valid}, 64'h0);
    chk(out_word, 64'h0);
    chk(in_cpu_word, 64'h0);
    @(posedge clk_sys) arst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      e = {i[0], i[3]};
      send(4'(15 - i), 4'(i), {e, 26'h25f00}, i[0]);
      chk(out_word, exp_w(4'(15 - i), 4'(i), {e, 26'h25f00}));
      chk({out_target, out_ext, out_is_dram, out_atomic, out_fm_used},
        {tgt_row[i], e, 4'(i) inside {4'h0, 4'hf},
         4'(i) inside {4'h3, 4'ha, 4'hb} || (i == 9 && e == 2'h3), fm_on(4'(i))});
    end
    // Back to back with the mask forced and the incoming path busy alongside
    @(posedge clk_sys);
    fm_force  <= 1'b1;
    stn       <= 4'h5;
    sel       <= 4'hd;
    ofs       <= 28'h3a45f00;
    out_valid <= 1'b1;
    in_valid  <= 1'b1;
    in_word   <= 64'hfedcba9876543210;
    @(posedge clk_sys);
    sel      <= 4'h8;
    in_valid <= 1'b0;
    #1 chk(out_word, exp_w(4'h5, 4'hd, 28'h3a45f00));
    chk(in_cpu_word, {in_word[63:36], in_word[39:32], in_word[27:0]});
    @(posedge clk_sys);
    out_valid <= 1'b0;
    #1 chk(out_word, exp_w(4'h5, 4'h8, 28'h3a45f00));
    chk({in_addr_valid, out_word_valid}, 64'h1);
    // Selector 0x8 on request alone, with the force bit off
    @(posedge clk_sys) fm_force <= 1'b0;
    send(4'h7, 4'h8, 28'h0123456, 1'b1);
    chk(out_word, exp_w(4'h7, 4'h8, 28'h0123456));
    chk(out_fm_used, 64'h1);
    // Mid-run reset clears the outputs at once, not at the next edge
    @(posedge clk_sys) arst_n <= 1'b0;
    #1 chk({out_word_valid, in_addr_valid, out_fm_used}, 64'h0);
    chk(out_word, 64'h0);
    @(posedge clk_sys) arst_n <= 1'b1;
    @(posedge clk_sys);
    #1 chk({out_word_valid, in_addr_valid}, 64'h0);
    send(4'h2, 4'hf, 28'h0000040, 1'b0);
    chk(out_word, exp_w(4'h2, 4'hf, 28'h0000040));
    give_verdict();
  end
endmodule // tb_top
bind ast_translator ast_translator_chk chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
  .out_valid(out_valid), .out_cpu_addr(out_cpu_addr), .filter_mask(filter_mask),
  .fm_force(fm_force), .source_id(source_id), .out_word_valid(out_word_valid),
  .out_word(out_word), .out_ext(out_ext), .out_is_dram(out_is_dram),
  .out_fm_used(out_fm_used), .in_valid(in_valid), .in_word(in_word),
  .in_cpu_word(in_cpu_word));
`default_nettype wire
